// ### hw/pgs_pkg.sv
// Purpose: shared constants of the pin group select and pull control block
// Assumes: 32-bit register bus with byte addresses, one word per register
// Notes:   offsets and the field layout of the group select word live here only
package pgs_pkg;

    // ------------------------
    // register map (byte addresses)
    // ------------------------
    localparam int         ADDR_W         = 5;
    localparam logic [4:0] OFS_WRITE_MASK = 5'h00;
    localparam logic [4:0] OFS_GROUP_SEL  = 5'h04;
    localparam logic [4:0] OFS_PULL_0     = 5'h08;
    localparam logic [4:0] OFS_PULL_3     = 5'h0c;
    localparam logic [4:0] OFS_STATUS     = 5'h10;

    // ------------------------
    // reset values
    // ------------------------
    localparam logic [31:0] RST_WRITE_MASK = 32'h0000_0000;
    localparam logic [31:0] RST_GROUP_SEL  = 32'h0000_0000;
    localparam logic [31:0] RST_PULL_0     = 32'h5d60_ffff;
    localparam logic [31:0] RST_PULL_3     = 32'hffff_ffff;

    // bits 11:0 of the group select word hold no storage
    localparam logic [31:0] GROUP_SEL_LIVE = 32'hffff_f000;

    // ------------------------
    // group select fields: lsb, width, number of pin groups
    // ------------------------
    localparam int S0_LSB = 30;
    localparam int S0_W   = 2;
    localparam int S0_N   = 4;
    localparam int S1_LSB = 28;
    localparam int S1_W   = 2;
    localparam int S1_N   = 3;
    localparam int S2_LSB = 26;
    localparam int S2_W   = 2;
    localparam int S2_N   = 3;
    localparam int S3_LSB = 25;
    localparam int S3_W   = 1;
    localparam int S3_N   = 2;
    localparam int S4_LSB = 22;
    localparam int S4_W   = 3;
    localparam int S4_N   = 5;
    localparam int AUDIO7_BIT = 14;
    localparam int AUDIO8_BIT = 13;

    // ------------------------
    // status word bits
    // ------------------------
    localparam int ST_ARMED       = 0;
    localparam int ST_REFUSED     = 1;
    localparam int ST_AUDIO_SPLIT = 2;

    // one-bit state: the two codes differ in one bit, Gray by construction
    typedef enum logic [0:0]
    {
        PGS_BUS_IDLE = 1'b0,
        PGS_BUS_DONE = 1'b1
    } pgs_bus_state_t;

endpackage : pgs_pkg

// ### hw/pgs_group_route.sv
// Purpose: connects one serial interface to at most one of N pin groups
// Assumes: group code is static while the interface is in use
// Notes:   an undefined code connects no group; inputs then read idle high
`timescale 1ns/1ps
`default_nettype none

module pgs_group_route #(
    parameter int N  = 2,
    parameter int SW = 1
) (
    input  wire logic [SW-1:0] group_sel,
    input  wire logic [N-1:0]  pin_rx_in,
    input  wire logic [N-1:0]  pin_clk_in,
    output logic      [N-1:0]  pin_tx_out,
    output logic      [N-1:0]  pin_tx_oe,
    output logic               core_rxd,
    output logic               core_clk,
    input  wire logic          core_txd
);

    // ------------------------
    // group decode
    // ------------------------
    logic known;

    assign known = {1'b0, group_sel} < (SW+1)'(N);

    // ------------------------
    // input side: only the chosen group reaches the core
    // ------------------------
    always_comb
    begin
        core_rxd = 1'b1;
        core_clk = 1'b1;
        if (known)
        begin
            core_rxd = pin_rx_in[group_sel];  // [R01]
            core_clk = pin_clk_in[group_sel]; // [R01]
        end
    end

    // ------------------------
    // output side: only the chosen group drives
    // ------------------------
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            pin_tx_out[i] = core_txd;
            pin_tx_oe[i]  = known && ({1'b0, group_sel} == (SW+1)'(i)); // [R01]
        end
    end

endmodule : pgs_group_route

`default_nettype wire

// ### hw/pgs_pin_group_ctrl.sv
// Purpose: pin group select, write mask and pull control registers with
//          the serial pin routing they steer
// Assumes: Avalon-MM slave, byte addresses, one 32-bit word per register
// Notes:   each access answers on the second clock edge after it appears
//
// How it works
// [R01] the group select word connects each serial interface to one pin group only
// [R02] software leaves pins of unselected groups unused; here they get transmit data but no output enable, and their inputs are ignored
// [R03] outputs without a group field are steered by software through function select
// [R04] software keeps audio channel 7 and 8 group bits equal; a mismatch shows in status
// [R05] a group select write is taken only right after a write to the write mask
// [R06] the group select word is read/write and resets to zero, first group everywhere
// [R07] bits 31:30 pick group 0 to 3 for serial 0 clock, receive and transmit
// [R08] bits 29:28 pick group 0 to 2 for serial 1; code 3 connects nothing
// [R09] bits 27:26 pick group 0 to 2 for serial 2; code 3 connects nothing
// [R10] bit 25 picks the primary or second group for serial 3
// [R11] bits 24:22 pick group 0 to 4 for serial 4 receive and transmit
// [R12] each pull control 0 bit enables one address or data pin pull when set
// [R13] pull control 0 is read/write and resets to 5d60ffff
// [R14] each pull control 3 bit enables one pin pull-up when set
// [R15] pull control 3 is read/write and resets to all ones
// [R16] group select bits 11:0 hold nothing, read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none

module pgs_pin_group_ctrl (
    input  wire logic                      ref_clk,
    input  wire logic                      rst,
    // ------------------------
    // register bus
    // ------------------------
    input  wire logic [pgs_pkg::ADDR_W-1:0] address,
    input  wire logic                      read,
    input  wire logic                      write,
    input  wire logic [31:0]               writedata,
    input  wire logic [3:0]                byteenable,
    output logic      [31:0]               readdata,
    output logic                           waitrequest,
    // ------------------------
    // serial 0 pins and core side
    // ------------------------
    input  wire logic [pgs_pkg::S0_N-1:0]  serial0_rx_pin_in,
    input  wire logic [pgs_pkg::S0_N-1:0]  serial0_clk_pin_in,
    output logic      [pgs_pkg::S0_N-1:0]  serial0_tx_pin_out,
    output logic      [pgs_pkg::S0_N-1:0]  serial0_tx_pin_oe,
    output logic                           serial0_rxd,
    output logic                           serial0_clk,
    input  wire logic                      serial0_txd,
    // ------------------------
    // serial 1
    // ------------------------
    input  wire logic [pgs_pkg::S1_N-1:0]  serial1_rx_pin_in,
    input  wire logic [pgs_pkg::S1_N-1:0]  serial1_clk_pin_in,
    output logic      [pgs_pkg::S1_N-1:0]  serial1_tx_pin_out,
    output logic      [pgs_pkg::S1_N-1:0]  serial1_tx_pin_oe,
    output logic                           serial1_rxd,
    output logic                           serial1_clk,
    input  wire logic                      serial1_txd,
    // ------------------------
    // serial 2
    // ------------------------
    input  wire logic [pgs_pkg::S2_N-1:0]  serial2_rx_pin_in,
    input  wire logic [pgs_pkg::S2_N-1:0]  serial2_clk_pin_in,
    output logic      [pgs_pkg::S2_N-1:0]  serial2_tx_pin_out,
    output logic      [pgs_pkg::S2_N-1:0]  serial2_tx_pin_oe,
    output logic                           serial2_rxd,
    output logic                           serial2_clk,
    input  wire logic                      serial2_txd,
    // ------------------------
    // serial 3
    // ------------------------
    input  wire logic [pgs_pkg::S3_N-1:0]  serial3_rx_pin_in,
    input  wire logic [pgs_pkg::S3_N-1:0]  serial3_clk_pin_in,
    output logic      [pgs_pkg::S3_N-1:0]  serial3_tx_pin_out,
    output logic      [pgs_pkg::S3_N-1:0]  serial3_tx_pin_oe,
    output logic                           serial3_rxd,
    output logic                           serial3_clk,
    input  wire logic                      serial3_txd,
    // ------------------------
    // serial 4 has no clock pin
    // ------------------------
    input  wire logic [pgs_pkg::S4_N-1:0]  serial4_rx_pin_in,
    output logic      [pgs_pkg::S4_N-1:0]  serial4_tx_pin_out,
    output logic      [pgs_pkg::S4_N-1:0]  serial4_tx_pin_oe,
    output logic                           serial4_rxd,
    input  wire logic                      serial4_txd,
    // ------------------------
    // configuration seen by the rest of the pad ring
    // ------------------------
    output logic      [31:0]               group_select,
    output logic                           audio7_pin_group,
    output logic                           audio8_pin_group,
    output logic      [31:0]               pull_enable_0,
    output logic      [31:0]               pull_enable_3
);

    // ------------------------
    // helpers
    // ------------------------
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0]  be
    );
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++)
            if (be[b])
                res[8*b +: 8] = new_val[8*b +: 8];
        return res;
    endfunction : merge_bytes

    // ------------------------
    // bus handshake
    // ------------------------
    pgs_pkg::pgs_bus_state_t bus_state_reg;
    pgs_pkg::pgs_bus_state_t bus_state_next;
    logic                    request;
    logic                    accept;
    assign request     = read || write;
    // one wait cycle: read data is fetched into a flop before it is shown
    assign waitrequest = request && (bus_state_reg != pgs_pkg::PGS_BUS_DONE);
    assign accept      = request && (bus_state_reg == pgs_pkg::PGS_BUS_DONE);

    always_comb
    begin
        case (bus_state_reg)
            pgs_pkg::PGS_BUS_IDLE:
            begin
                bus_state_next = request ? pgs_pkg::PGS_BUS_DONE : pgs_pkg::PGS_BUS_IDLE;
            end
            pgs_pkg::PGS_BUS_DONE: bus_state_next = pgs_pkg::PGS_BUS_IDLE;
            default:               bus_state_next = pgs_pkg::PGS_BUS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            bus_state_reg <= pgs_pkg::PGS_BUS_IDLE;
        end
        else
        begin
            bus_state_reg <= bus_state_next;
        end
    end

    // ------------------------
    // write decode
    // ------------------------
    logic wr_mask;
    logic wr_group;
    logic wr_pull0;
    logic wr_pull3;
    logic wr_status;
    assign wr_mask   = accept && write && (address == pgs_pkg::OFS_WRITE_MASK);
    assign wr_group  = accept && write && (address == pgs_pkg::OFS_GROUP_SEL);
    assign wr_pull0  = accept && write && (address == pgs_pkg::OFS_PULL_0);
    assign wr_pull3  = accept && write && (address == pgs_pkg::OFS_PULL_3);
    assign wr_status = accept && write && (address == pgs_pkg::OFS_STATUS);

    // ------------------------
    // write mask and unlock
    // ------------------------
    logic [31:0] write_mask_reg;
    logic        armed_reg;
    logic        refused_reg;
    logic        group_take;

    // the unlock lasts for exactly one following write, whatever its target
    assign group_take = wr_group && armed_reg; // [R05]

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            write_mask_reg <= pgs_pkg::RST_WRITE_MASK;
        end
        else if (wr_mask)
        begin
            write_mask_reg <= merge_bytes(write_mask_reg, writedata, byteenable);
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            armed_reg <= 1'b0;
        end
        else if (accept && write)
        begin
            armed_reg <= wr_mask; // [R05]
        end
    end

    // sticky record of a group select write without unlock; set beats clear
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            refused_reg <= 1'b0;
        end
        else if (wr_group && !armed_reg)
        begin
            refused_reg <= 1'b1; // [R05]
        end
        else if (wr_status && byteenable[0] && writedata[pgs_pkg::ST_REFUSED])
        begin
            refused_reg <= 1'b0;
        end
    end

    // ------------------------
    // group select and pull control storage
    // ------------------------
    logic [31:0] group_sel_reg;
    logic [31:0] pull0_reg;
    logic [31:0] pull3_reg;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            group_sel_reg <= pgs_pkg::RST_GROUP_SEL; // [R06]
        end
        else if (group_take)
        begin
            group_sel_reg <= merge_bytes(group_sel_reg, writedata, byteenable)
                             & pgs_pkg::GROUP_SEL_LIVE; // [R06] [R16]
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            pull0_reg <= pgs_pkg::RST_PULL_0; // [R13]
        end
        else if (wr_pull0)
        begin
            pull0_reg <= merge_bytes(pull0_reg, writedata, byteenable); // [R13]
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            pull3_reg <= pgs_pkg::RST_PULL_3; // [R15]
        end
        else if (wr_pull3)
        begin
            pull3_reg <= merge_bytes(pull3_reg, writedata, byteenable); // [R15]
        end
    end

    assign pull_enable_0 = pull0_reg; // [R12]
    assign pull_enable_3 = pull3_reg; // [R14]
    assign group_select  = group_sel_reg;

    // ------------------------
    // audio channel groups
    // ------------------------
    logic audio_split;

    assign audio7_pin_group = group_sel_reg[pgs_pkg::AUDIO7_BIT];
    assign audio8_pin_group = group_sel_reg[pgs_pkg::AUDIO8_BIT];
    // only flagged: the block cannot know whether both channels are in use
    assign audio_split      = audio7_pin_group != audio8_pin_group; // [R04]

    // ------------------------
    // read path
    // ------------------------
    logic [31:0] read_word;

    always_comb
    begin
        read_word = 32'h0000_0000;
        case (address)
            pgs_pkg::OFS_WRITE_MASK: read_word = write_mask_reg;
            pgs_pkg::OFS_GROUP_SEL:  read_word = group_sel_reg; // [R16]
            pgs_pkg::OFS_PULL_0:     read_word = pull0_reg;
            pgs_pkg::OFS_PULL_3:     read_word = pull3_reg;
            pgs_pkg::OFS_STATUS:
            begin
                read_word[pgs_pkg::ST_ARMED]       = armed_reg;
                read_word[pgs_pkg::ST_REFUSED]     = refused_reg;
                read_word[pgs_pkg::ST_AUDIO_SPLIT] = audio_split;
            end
            default:                 read_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            readdata <= 32'h0000_0000;
        end
        else if (read && (bus_state_reg == pgs_pkg::PGS_BUS_IDLE))
        begin
            readdata <= read_word;
        end
    end

    // ------------------------
    // pin routing; unselected groups neither drive nor feed the core [R02]
    // ------------------------
    pgs_group_route #(.N(pgs_pkg::S0_N), .SW(pgs_pkg::S0_W)) u_route_serial0 (
        .group_sel  (group_sel_reg[pgs_pkg::S0_LSB +: pgs_pkg::S0_W]), // [R07]
        .pin_rx_in  (serial0_rx_pin_in),
        .pin_clk_in (serial0_clk_pin_in),
        .pin_tx_out (serial0_tx_pin_out),
        .pin_tx_oe  (serial0_tx_pin_oe),
        .core_rxd   (serial0_rxd),
        .core_clk   (serial0_clk),
        .core_txd   (serial0_txd)
    );

    pgs_group_route #(.N(pgs_pkg::S1_N), .SW(pgs_pkg::S1_W)) u_route_serial1 (
        .group_sel  (group_sel_reg[pgs_pkg::S1_LSB +: pgs_pkg::S1_W]), // [R08]
        .pin_rx_in  (serial1_rx_pin_in),
        .pin_clk_in (serial1_clk_pin_in),
        .pin_tx_out (serial1_tx_pin_out),
        .pin_tx_oe  (serial1_tx_pin_oe),
        .core_rxd   (serial1_rxd),
        .core_clk   (serial1_clk),
        .core_txd   (serial1_txd)
    );

    pgs_group_route #(.N(pgs_pkg::S2_N), .SW(pgs_pkg::S2_W)) u_route_serial2 (
        .group_sel  (group_sel_reg[pgs_pkg::S2_LSB +: pgs_pkg::S2_W]), // [R09]
        .pin_rx_in  (serial2_rx_pin_in),
        .pin_clk_in (serial2_clk_pin_in),
        .pin_tx_out (serial2_tx_pin_out),
        .pin_tx_oe  (serial2_tx_pin_oe),
        .core_rxd   (serial2_rxd),
        .core_clk   (serial2_clk),
        .core_txd   (serial2_txd)
    );

    pgs_group_route #(.N(pgs_pkg::S3_N), .SW(pgs_pkg::S3_W)) u_route_serial3 (
        .group_sel  (group_sel_reg[pgs_pkg::S3_LSB +: pgs_pkg::S3_W]), // [R10]
        .pin_rx_in  (serial3_rx_pin_in),
        .pin_clk_in (serial3_clk_pin_in),
        .pin_tx_out (serial3_tx_pin_out),
        .pin_tx_oe  (serial3_tx_pin_oe),
        .core_rxd   (serial3_rxd),
        .core_clk   (serial3_clk),
        .core_txd   (serial3_txd)
    );

    // no clock on this interface, so the clock path is fed idle high
    pgs_group_route #(.N(pgs_pkg::S4_N), .SW(pgs_pkg::S4_W)) u_route_serial4 (
        .group_sel  (group_sel_reg[pgs_pkg::S4_LSB +: pgs_pkg::S4_W]), // [R11]
        .pin_rx_in  (serial4_rx_pin_in),
        .pin_clk_in ({pgs_pkg::S4_N{1'b1}}),
        .pin_tx_out (serial4_tx_pin_out),
        .pin_tx_oe  (serial4_tx_pin_oe),
        .core_rxd   (serial4_rxd),
        .core_clk   (),
        .core_txd   (serial4_txd)
    );

endmodule : pgs_pin_group_ctrl

`default_nettype wire

// ### tb/pgs_checker_properties.sv
// Purpose: concurrent checks on the ports of the pin group control block
// Assumes: group select writes use all four byte lanes
// Notes:   armed_reg mirrors whether the last completed write hit the mask
`timescale 1ns/1ps
`default_nettype none
module pgs_checker (
    input wire logic                       ref_clk,
    input wire logic                       rst,
    input wire logic [pgs_pkg::ADDR_W-1:0] address,
    input wire logic                       read,
    input wire logic                       write,
    input wire logic [31:0]                writedata,
    input wire logic [3:0]                 byteenable,
    input wire logic                       waitrequest,
    input wire logic [3:0]                 serial0_rx_pin_in,
    input wire logic                       serial0_rxd,
    input wire logic [3:0]                 serial0_tx_pin_oe,
    input wire logic [2:0]                 serial1_tx_pin_oe,
    input wire logic [1:0]                 serial3_tx_pin_oe,
    input wire logic [4:0]                 serial4_tx_pin_oe,
    input wire logic [31:0]                group_select,
    input wire logic                       audio7_pin_group,
    input wire logic [31:0]                pull_enable_0,
    input wire logic [31:0]                pull_enable_3
);
    logic armed_reg;
    logic done;
    assign done = write && !waitrequest;
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            armed_reg <= 1'b0;
        else if (done)
            armed_reg <= (address == pgs_pkg::OFS_WRITE_MASK);
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_wait; (read || write) && !waitrequest |-> $past(waitrequest); endproperty
    a_wait: assert property (p_wait) else $error("answer without wait cycle");
    property p_refuse; done && address == 5'h04 && !armed_reg |=> $stable(group_select); endproperty
    a_refuse: assert property (p_refuse) else $error("unarmed select write taken");
    property p_take;
        done && address == 5'h04 && armed_reg && byteenable == 4'hf
        |=> group_select == ($past(writedata) & 32'hffff_f000);
    endproperty
    a_take: assert property (p_take) else $error("armed select write lost");
    property p_oe0; serial0_tx_pin_oe == 4'h1 << group_select[31:30]; endproperty
    a_oe0: assert property (p_oe0) else $error("serial0 enable wrong");
    property p_rx0; serial0_rxd == serial0_rx_pin_in[group_select[31:30]]; endproperty
    a_rx0: assert property (p_rx0) else $error("serial0 receive wrong");
    property p_oe1;
        serial1_tx_pin_oe == ((group_select[29:28] == 2'h3) ? 3'h0 : 3'h1 << group_select[29:28]);
    endproperty
    a_oe1: assert property (p_oe1) else $error("serial1 enable wrong");
    property p_oe3; serial3_tx_pin_oe == 2'h1 << group_select[25]; endproperty
    a_oe3: assert property (p_oe3) else $error("serial3 enable wrong");
    property p_oe4;
        serial4_tx_pin_oe == ((group_select[24:22] > 3'h4) ? 5'h0 : 5'h1 << group_select[24:22]);
    endproperty
    a_oe4: assert property (p_oe4) else $error("serial4 enable wrong");
    property p_low; group_select[11:0] == 12'h0 && audio7_pin_group == group_select[14]; endproperty
    a_low: assert property (p_low) else $error("select low bits or audio wrong");
    property p_prst; $fell(rst) |-> pull_enable_0 == 32'h5d60_ffff && &pull_enable_3; endproperty
    a_prst: assert property (p_prst) else $error("pull reset value wrong");
endmodule : pgs_checker
bind pgs_pin_group_ctrl pgs_checker chk_u (.ref_clk, .rst, .address, .read, .write, .writedata,
    .byteenable, .waitrequest, .serial0_rx_pin_in, .serial0_rxd, .serial0_tx_pin_oe,
    .serial1_tx_pin_oe, .serial3_tx_pin_oe, .serial4_tx_pin_oe, .group_select,
    .audio7_pin_group, .pull_enable_0, .pull_enable_3);
`default_nettype wire

// ### tb/tb.sv
// Purpose: self-checking bench for the pin group control block
// Assumes: one idle cycle between bus requests
// Notes:   undefined group codes must read idle high
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  address = 5'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic        txd = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0]  byteenable = 4'hf;
    logic [31:0] readdata, group_select, pull_enable_0, pull_enable_3;
    logic        waitrequest, audio7_pin_group, audio8_pin_group, rd0, rd1, rd2, rd3, rd4;
    logic        cl0, cl1, cl2, cl3;
    logic [3:0]  rx0 = 4'ha, ck0 = 4'h5, oe0, to0;
    logic [2:0]  rx1 = 3'h5, ck1 = 3'h2, oe1, rx2 = 3'h2, ck2 = 3'h5, oe2;
    logic [1:0]  rx3 = 2'h2, ck3 = 2'h1, oe3;
    logic [4:0]  rx4 = 5'h0a, oe4, to4;
    int          fail_count = 0, num_checks = 0, cycles = 0;
    pgs_pin_group_ctrl dut_u (.ref_clk, .rst, .address, .read, .write, .writedata, .byteenable,
        .readdata, .waitrequest, .group_select, .audio7_pin_group, .audio8_pin_group,
        .pull_enable_0, .pull_enable_3,
        .serial0_rx_pin_in(rx0), .serial0_clk_pin_in(ck0), .serial0_tx_pin_out(to0),
        .serial0_tx_pin_oe(oe0), .serial0_rxd(rd0), .serial0_clk(cl0), .serial0_txd(txd),
        .serial1_rx_pin_in(rx1), .serial1_clk_pin_in(ck1), .serial1_tx_pin_out(),
        .serial1_tx_pin_oe(oe1), .serial1_rxd(rd1), .serial1_clk(cl1), .serial1_txd(txd),
        .serial2_rx_pin_in(rx2), .serial2_clk_pin_in(ck2), .serial2_tx_pin_out(),
        .serial2_tx_pin_oe(oe2), .serial2_rxd(rd2), .serial2_clk(cl2), .serial2_txd(txd),
        .serial3_rx_pin_in(rx3), .serial3_clk_pin_in(ck3), .serial3_tx_pin_out(),
        .serial3_tx_pin_oe(oe3), .serial3_rxd(rd3), .serial3_clk(cl3), .serial3_txd(txd),
        .serial4_rx_pin_in(rx4), .serial4_tx_pin_out(to4), .serial4_tx_pin_oe(oe4),
        .serial4_rxd(rd4), .serial4_txd(txd));
    always #5 ref_clk = ~ref_clk;
    task automatic end_sim;
        if (fail_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim
    // a hang in a bus wait ends here instead of running forever
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
        @(posedge ref_clk);
    endtask : bus_wr
    task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
        address <= a;
        read <= 1'b1;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        d = readdata;
        read <= 1'b0;
        @(posedge ref_clk);
    endtask : bus_rd
    function automatic logic [4:0] onehot(input int c, input int n);
        return (c < n) ? 5'h1 << c : 5'h0;
    endfunction : onehot
    function automatic logic pick(input logic [4:0] p, input int c, input int n);
        return (c < n) ? p[c] : 1'b1;
    endfunction : pick
    task automatic t_reset;
        logic [31:0] d;
        chk("oe0_rst", 32'h1, oe0);
        bus_rd(5'h04, d);
        chk("sel_rst", 32'h0, d);
        bus_rd(5'h08, d);
        chk("pull0_rst", 32'h5d60_ffff, d);
        bus_rd(5'h0c, d);
        chk("pull3_rst", 32'hffff_ffff, d);
    endtask : t_reset
    task automatic t_refuse;
        logic [31:0] d;
        bus_wr(5'h04, 32'hffff_ffff);
        bus_rd(5'h04, d);
        chk("sel_no_mask", 32'h0, d);
        bus_rd(5'h10, d);
        chk("refused_flag", 32'h2, d & 32'h2);
        bus_wr(5'h00, 32'h1);
        bus_wr(5'h08, 32'h5d60_ffff);
        bus_wr(5'h04, 32'hffff_ffff);
        bus_rd(5'h04, d);
        chk("sel_after_other", 32'h0, d);
        bus_wr(5'h10, 32'h2);
        bus_wr(5'h00, 32'h1);
        bus_rd(5'h10, d);
        chk("armed_refused_clear", 32'h1, d & 32'h3);
        bus_wr(5'h04, 32'h4000_0000);
        bus_rd(5'h04, d);
        chk("sel_after_read", 32'h4000_0000, d);
    endtask : t_refuse
    task automatic try_sel(input logic [31:0] w);
        logic [31:0] d;
        txd <= w[0];
        bus_wr(5'h00, 32'h1);
        bus_wr(5'h04, w);
        bus_rd(5'h10, d);
        chk("audio_split", {w[14] ^ w[13], 2'h0}, d & 32'h4);
        #1;
        chk("oe0", onehot(w[31:30], 4), oe0);
        chk("rxd0", pick(rx0, w[31:30], 4), rd0);
        chk("clk0", pick(ck0, w[31:30], 4), cl0);
        chk("tx0", {4{w[0]}}, to0);
        chk("oe1", onehot(w[29:28], 3), oe1);
        chk("rxd1", pick(rx1, w[29:28], 3), rd1);
        chk("clk1", pick(ck1, w[29:28], 3), cl1);
        chk("oe2", onehot(w[27:26], 3), oe2);
        chk("rxd2", pick(rx2, w[27:26], 3), rd2);
        chk("clk2", pick(ck2, w[27:26], 3), cl2);
        chk("oe3", onehot(w[25], 2), oe3);
        chk("rxd3", pick(rx3, w[25], 2), rd3);
        chk("clk3", pick(ck3, w[25], 2), cl3);
        chk("oe4", onehot(w[24:22], 5), oe4);
        chk("rxd4", pick(rx4, w[24:22], 5), rd4);
        chk("tx4", {5{w[0]}}, to4);
        chk("group_select", w & 32'hffff_f000, group_select);
        chk("audio", {w[14], w[13]}, {audio7_pin_group, audio8_pin_group});
        @(posedge ref_clk);
    endtask : try_sel
    task automatic t_pull;
        logic [31:0] d;
        bus_wr(5'h08, 32'ha5a5_0f0f);
        bus_wr(5'h0c, 32'h0000_00ff);
        bus_rd(5'h08, d);
        chk("pull0", 32'ha5a5_0f0f, d);
        chk("pull0_out", 32'ha5a5_0f0f, pull_enable_0);
        bus_rd(5'h0c, d);
        chk("pull3", 32'h0000_00ff, d);
        chk("pull3_out", 32'h0000_00ff, pull_enable_3);
        bus_rd(5'h1c, d);
        chk("unmapped", 32'h0, d);
    endtask : t_pull
    initial
    begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_refuse();
        for (int k = 0; k < 8; k++)
            try_sel({k[1:0], k[1:0], k[1:0], k[0], k[2:0], 7'h55, k[0], k[1], 12'hfff, k[0]});
        t_pull();
        end_sim();
    end
endmodule : tb
`default_nettype wire
